// ===== hdl/maw_pkg.sv
/*
 * maw_pkg: constants and types shared by the multiplexed analog input word block.
 * Assumes a 32-bit APB register bus and four analog channels.
 */
`default_nettype none
package maw_pkg;
    localparam int unsigned CHANNELS = 4;
    localparam int unsigned SAMPLE_W = 16;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_WORD     = 8'h04;
    localparam logic [7:0] OFS_INT_STAT = 8'h08;
    localparam logic [7:0] OFS_INT_MASK = 8'h0c;
    localparam logic [7:0] OFS_SCANS    = 8'h10;

    // control field positions
    localparam int unsigned CTRL_FMT_LSB   = 0;
    localparam int unsigned CTRL_OPEN_BIT  = 2;
    localparam int unsigned CTRL_CHAN_LSB  = 3;
    localparam int unsigned CTRL_EN_BIT    = 5;
    localparam int unsigned CTRL_W         = 6;
    localparam logic [5:0]  CTRL_RESET     = 6'h00;

    // interrupt status bits
    localparam int unsigned INT_SCAN_BIT = 0;
    localparam int unsigned INT_OPEN_BIT = 1;
    localparam int unsigned INT_W        = 2;
    localparam logic [1:0]  INT_RESET    = 2'h0;

    // input word layout
    localparam int unsigned WORD_ACTIVE_LSB = 16;
    localparam int unsigned WORD_SIGN_LSB   = 20;
    localparam int unsigned WORD_OPEN_LSB   = 24;
    localparam logic [31:0] WORD_RESET      = 32'h0000_0000;

    // full-scale limits
    localparam logic [16:0] MAX_12BIT = 17'h00fff;
    localparam logic [16:0] MAX_13BIT = 17'h01fff;

    typedef enum logic [1:0] {
        FMT_BIN12 = 2'b00,
        FMT_SM13  = 2'b01,
        FMT_TWOS  = 2'b10,
        FMT_BCD   = 2'b11
    } maw_fmt_t;
endpackage
`default_nettype wire

// ===== hdl/maw_conv_if.sv
/*
 * maw_conv_if: one channel's raw sample, chosen format and converted result.
 * Assumes the converter is purely combinational.
 */
`timescale 1ns/10ps
`default_nettype none
interface maw_conv_if;
    maw_pkg::maw_fmt_t fmt;
    logic [15:0]       sample;
    logic [15:0]       data;
    logic              negative;

    modport conv (input fmt, input sample, output data, output negative);
    modport user (output fmt, output sample, input data, input negative);
endinterface
`default_nettype wire

// ===== hdl/maw_conv.sv
/*
 * maw_conv: turns one signed 16-bit sample into the lower-word encoding.
 * Assumes samples arrive as two's complement counts from the front end.
 */
`timescale 1ns/10ps
`default_nettype none
module maw_conv (
    // channel
    maw_conv_if.conv bus
);
    function automatic logic [15:0] to_bcd(input logic [11:0] bin);
        logic [15:0] acc;
        acc = 16'h0000;
        for (int i = 11; i >= 0; i--) begin
            for (int d = 0; d < 4; d++) begin
                if (acc[d*4 +: 4] > 4'h4) begin
                    acc[d*4 +: 4] = acc[d*4 +: 4] + 4'h3;
                end
            end
            acc = {acc[14:0], bin[i]};
        end
        return acc;
    endfunction

    function automatic logic [16:0] clamp(input logic [16:0] v, input logic [16:0] lim);
        return (v > lim) ? lim : v;
    endfunction

    logic        neg;
    logic [16:0] mag;
    logic [16:0] lim12;
    logic [16:0] lim13;

    always_comb begin
        neg   = bus.sample[15];
        mag   = neg ? (~{1'b1, bus.sample} + 17'h00001) : {1'b0, bus.sample};
        lim12 = clamp(mag, maw_pkg::MAX_12BIT);
        lim13 = clamp(mag, maw_pkg::MAX_13BIT);
        bus.data     = 16'h0000;
        bus.negative = 1'b0;
        unique case (bus.fmt)
            maw_pkg::FMT_BIN12: begin
                // unipolar count 0..4095, top nibble zero
                bus.data = neg ? 16'h0000 : {4'h0, lim12[11:0]};
            end
            maw_pkg::FMT_SM13: begin
                // sign lives in the upper word, not here
                bus.data     = {3'h0, lim13[12:0]};
                bus.negative = neg;
            end
            maw_pkg::FMT_TWOS: begin
                // all 16 bits carry data
                bus.data = bus.sample;
            end
            maw_pkg::FMT_BCD: begin
                // bipolar reading already in bcd
                bus.data     = to_bcd(lim12[11:0]);
                bus.negative = neg;
            end
        endcase
    end
endmodule
`default_nettype wire

// ===== hdl/maw_top.sv
/*
 * maw_top: 32-point input word of a four-channel multiplexed analog input.
 * Assumes samples and comparator levels come from an unsynchronised front end,
 * scan_req is a pulse level from the cpu side, and software uses apb.
 */
// Implementation choices: the address map and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module maw_top (
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // analog front end
    input  wire logic [63:0] adc_sample,
    input  wire logic [3:0]  current_low,
    // cpu scan side
    input  wire logic        scan_req,
    output logic      [31:0] input_word,
    // interrupt
    output logic             irq
);
    typedef struct packed {
        logic [3:0][15:0] samp_s1;
        logic [3:0][15:0] samp_s2;
        logic [3:0]       low_s1;
        logic [3:0]       low_s2;
        logic             scan_s1;
        logic             scan_s2;
        logic             scan_d;
        logic [1:0]       chan;
        logic [5:0]       ctrl;
        logic [1:0]       int_stat;
        logic [1:0]       int_mask;
        logic [31:0]      scans;
        logic [31:0]      word;
        logic [31:0]      rdata;
        logic             ready;
        logic             slverr;
        logic             irq;
    } maw_state_t;

    maw_state_t cur;
    maw_state_t next_s;

    maw_conv_if conv_bus [4] ();
    logic [3:0][15:0] conv_data;
    logic [3:0]       conv_neg;

    maw_pkg::maw_fmt_t fmt;
    assign fmt = maw_pkg::maw_fmt_t'(cur.ctrl[maw_pkg::CTRL_FMT_LSB +: 2]);

    // each channel has its own converter so sign flags of idle channels stay live
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_conv
            assign conv_bus[g].fmt    = fmt;
            assign conv_bus[g].sample = cur.samp_s2[g];
            assign conv_data[g]       = conv_bus[g].data;
            assign conv_neg[g]        = conv_bus[g].negative;
            maw_conv u_conv (
                .bus (conv_bus[g].conv)
            );
        end
    endgenerate

    function automatic logic [3:0] enabled_mask(input logic [1:0] count_m1);
        logic [3:0] m;
        m = 4'h0;
        for (int i = 0; i < 4; i++) begin
            m[i] = (2'(i) <= count_m1);
        end
        return m;
    endfunction

    function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    logic [1:0]  chan_m1;
    logic [3:0]  en_mask;
    logic [1:0]  next_chan;
    logic [3:0]  sign_flags;
    logic [3:0]  open_flags;
    logic [3:0]  active;
    logic        scan_edge;
    logic        setup;
    logic        access;
    logic        mapped;
    logic [1:0]  int_set;
    logic [1:0]  int_clr;

    always_comb begin
        next_s = cur;

        // pins pass two flops before anything looks at them
        next_s.samp_s1 = adc_sample;
        next_s.samp_s2 = cur.samp_s1;
        next_s.low_s1  = current_low;
        next_s.low_s2  = cur.low_s1;
        next_s.scan_s1 = scan_req;
        next_s.scan_s2 = cur.scan_s1;
        next_s.scan_d  = cur.scan_s2;
        scan_edge      = cur.scan_s2 & ~cur.scan_d & cur.ctrl[maw_pkg::CTRL_EN_BIT];

        chan_m1 = cur.ctrl[maw_pkg::CTRL_CHAN_LSB +: 2];
        en_mask = enabled_mask(chan_m1);

        // ascending order, wrapping at the last enabled channel
        // a single channel keeps pointing at channel 1
        next_chan = (cur.chan >= chan_m1) ? 2'h0 : cur.chan + 2'h1;

        // sign flags only for enabled channels in the FMT_SM13 and FMT_BCD formats
        for (int i = 0; i < 4; i++) begin
            sign_flags[i] = conv_neg[i] & en_mask[i];
            open_flags[i] = cur.low_s2[i] & en_mask[i] & cur.ctrl[maw_pkg::CTRL_OPEN_BIT];
        end
        active = 4'h1 << next_chan;

        int_set = 2'h0;
        if (scan_edge) begin
            next_s.chan  = next_chan;
            next_s.scans = cur.scans + 32'h1;
            // data, flags and status move in one register write
            next_s.word = {4'h0,
                           open_flags,
                           sign_flags,
                           active,
                           conv_data[next_chan]};
            int_set[maw_pkg::INT_SCAN_BIT] = 1'b1;
            int_set[maw_pkg::INT_OPEN_BIT] = |open_flags;
        end else if (!cur.ctrl[maw_pkg::CTRL_EN_BIT]) begin
            // disabled: present nothing; pointer parks on the last code so
            // the first scan after enable wraps to channel 1 for any count
            next_s.chan = 2'h3;
            next_s.word = maw_pkg::WORD_RESET;
        end

        // apb: answer is prepared in setup so pready comes from a flop
        setup  = psel & ~penable;
        access = psel & penable & cur.ready;
        mapped = is_reg(paddr, maw_pkg::OFS_CTRL) | is_reg(paddr, maw_pkg::OFS_WORD)
               | is_reg(paddr, maw_pkg::OFS_INT_STAT) | is_reg(paddr, maw_pkg::OFS_INT_MASK)
               | is_reg(paddr, maw_pkg::OFS_SCANS);
        next_s.ready  = setup;
        next_s.slverr = setup & ~mapped;
        next_s.rdata  = 32'h0000_0000;
        if (setup & ~pwrite) begin
            if (is_reg(paddr, maw_pkg::OFS_CTRL)) begin
                next_s.rdata = {26'h0, cur.ctrl};
            end else if (is_reg(paddr, maw_pkg::OFS_WORD)) begin
                next_s.rdata = cur.word;
            end else if (is_reg(paddr, maw_pkg::OFS_INT_STAT)) begin
                next_s.rdata = {30'h0, cur.int_stat};
            end else if (is_reg(paddr, maw_pkg::OFS_INT_MASK)) begin
                next_s.rdata = {30'h0, cur.int_mask};
            end else if (is_reg(paddr, maw_pkg::OFS_SCANS)) begin
                next_s.rdata = cur.scans;
            end
        end

        int_clr = 2'h0;
        if (access & pwrite) begin
            if (is_reg(paddr, maw_pkg::OFS_CTRL)) begin
                next_s.ctrl = pwdata[maw_pkg::CTRL_W-1:0];
            end
            if (is_reg(paddr, maw_pkg::OFS_INT_STAT)) begin
                int_clr = pwdata[maw_pkg::INT_W-1:0];
            end
            if (is_reg(paddr, maw_pkg::OFS_INT_MASK)) begin
                next_s.int_mask = pwdata[maw_pkg::INT_W-1:0];
            end
        end

        // a new event in the clearing cycle survives the clear
        next_s.int_stat = (cur.int_stat & ~int_clr) | int_set;
        next_s.irq      = |(next_s.int_stat & next_s.int_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur          <= '0;
            cur.ctrl     <= maw_pkg::CTRL_RESET;
            cur.int_stat <= maw_pkg::INT_RESET;
            cur.int_mask <= maw_pkg::INT_RESET;
            cur.word     <= maw_pkg::WORD_RESET;
        end else begin
            cur <= next_s;
        end
    end

    assign prdata     = cur.rdata;
    assign pready     = cur.ready;
    assign pslverr    = cur.slverr;
    assign input_word = cur.word;
    assign irq        = cur.irq;
endmodule
`default_nettype wire

// ===== sim/maw_checker.sv
/*
 * maw_checker: port-level assertions for maw_top.
 * Assumes single pclk domain and async active-low presetn.
 */
`timescale 1ns/10ps
`default_nettype none
module maw_checker (
    // apb
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // scan side
    input wire logic        scan_req,
    input wire logic [31:0] input_word
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence
    // word may move at the access edge; only compare when it held still
    sequence s_word_rd;
        (s_setup and (!pwrite && paddr == 8'h04)) ##1 $stable(input_word);
    endsequence

    AST_TOP_ZERO: assert property (input_word[31:28] == 4'h0)
        else $error("upper word unused bits not zero");
    AST_ONE_FLAG: assert property ($onehot0(input_word[19:16]))
        else $error("more than one active flag");
    AST_DATA_FLAG: assert property (input_word[15:0] != 16'h0 |-> input_word[19:16] != 4'h0)
        else $error("data shown without active flag");
    AST_WORD_ON_SCAN: assert property ($changed(input_word) && input_word != 32'h0 |->
        $past(scan_req, 3) && !$past(scan_req, 4))
        else $error("word changed without a scan edge");
    AST_WORD_READ: assert property (s_word_rd |-> pready && !pslverr && prdata == input_word)
        else $error("register read of word differs");
    AST_PREADY_NEXT: assert property (s_setup |=> pready ##1 !pready)
        else $error("ready not one cycle after setup");
    AST_BAD_ADDR: assert property ((s_setup and (paddr == 8'h14)) |=> pready && pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("error without ready");
endmodule
bind maw_top maw_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
    .pready, .pslverr, .scan_req, .input_word);
`default_nettype wire

// ===== sim/maw_cpu_model.sv
/*
 * maw_cpu_model: cpu side that scans the 32-point input word.
 * Assumes the word settles 3 edges after scan_req rises.
 */
`timescale 1ns/10ps
`default_nettype none
module maw_cpu_model (
    // scan side
    input  wire logic        pclk,
    output var  logic        scan_req,
    input  wire logic [31:0] input_word
);
    initial scan_req = 1'b0;
    // one scan; low time lets the synchroniser see the fall
    task automatic scan(output logic [31:0] w);
        @(posedge pclk);
        scan_req <= 1'b1;
        repeat (4) @(posedge pclk);
        w = input_word;
        scan_req <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// ===== sim/maw_top_tb.sv
/*
 * maw_top_tb: self-checking bench for maw_top.
 * Assumes apb at offsets of maw_pkg and the cpu model for scans.
 */
`timescale 1ns/10ps
`default_nettype none
module maw_top_tb;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, input_word, rd, w;
    logic [63:0] adc_sample = 64'h0;
    logic [3:0]  current_low = 4'hf;
    logic        pready, pslverr, irq, scan_req, er;
    int          n_fail = 0, n_compared = 0;
    // ctrl, ch1 sample, expected word
    logic [55:0] rows [9] = '{56'h20_0123_00010123, 56'h20_7fff_00010fff, 56'h20_ff00_00010000,
        56'h21_fffb_00110005, 56'h21_7fff_00011fff, 56'h22_fffb_0001fffb, 56'h23_04d2_00011234,
        56'h23_ff9d_00110099, 56'h24_0000_01010000};

    always #2.5 pclk = ~pclk;

    maw_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .adc_sample, .current_low, .scan_req, .input_word, .irq);
    maw_cpu_model u_cpu (.pclk, .scan_req, .input_word);

    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_compared++;
        if (got !== ex) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 8; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 8) begin
            n_fail++;
            complete_run();
        end
    endtask

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("word after reset", 32'h0, input_word);
        chk("irq after reset", 32'h0, {31'h0, irq});
        apb(1'b0, 8'h00, 32'h0, rd, er);
        chk("ctrl reset", 32'h0, rd);
        for (int i = 0; i < 9; i++) begin
            apb(1'b1, 8'h00, {24'h0, rows[i][55:48]}, rd, er);
            adc_sample <= {48'h8001_8001_8001, rows[i][47:32]};
            u_cpu.scan(w);
            chk("row word", rows[i][31:0], w);
        end
        apb(1'b1, 8'h00, 32'h0, rd, er);
        u_cpu.scan(w);
        chk("word disabled", 32'h0, w);
        apb(1'b1, 8'h00, 32'h38, rd, er);
        adc_sample <= 64'h0040_0030_0020_0010;
        for (int i = 0; i < 5; i++) begin
            u_cpu.scan(w);
            chk("mux word", {12'h0, 4'(1 << (i % 4)), 16'(16 * (i % 4 + 1))}, w);
        end
        apb(1'b0, 8'h04, 32'h0, rd, er);
        chk("word register", 32'h0001_0010, rd);
        // earlier scans left both sticky bits set; clear them first
        apb(1'b1, 8'h08, 32'h3, rd, er);
        apb(1'b1, 8'h0c, 32'h1, rd, er);
        chk("irq before scan", 32'h0, {31'h0, irq});
        u_cpu.scan(w);
        chk("irq on scan", 32'h1, {31'h0, irq});
        apb(1'b0, 8'h08, 32'h0, rd, er);
        chk("status set", 32'h1, rd);
        apb(1'b1, 8'h08, 32'h1, rd, er);
        apb(1'b0, 8'h08, 32'h0, rd, er);
        chk("status cleared", 32'h0, rd);
        chk("irq cleared", 32'h0, {31'h0, irq});
        apb(1'b1, 8'h0c, 32'h0, rd, er);
        u_cpu.scan(w);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b0, 8'h08, 32'h0, rd, er);
        chk("status masked", 32'h1, rd);
        // comparators released: detection on, no open-loop flag expected
        current_low <= 4'h0;
        apb(1'b1, 8'h00, 32'h24, rd, er);
        u_cpu.scan(w);
        chk("open flag clear", 32'h0001_0010, w);
        apb(1'b0, 8'h14, 32'h0, rd, er);
        chk("unmapped err", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        complete_run();
    end
endmodule
`default_nettype wire
